// file: src/can_filter_pkg.sv
// How it works
// - Type bit clear with mask type-match set: filter takes standard frames only, comparing the 11-bit identifier.
// - Type bit set with mask type-match set, payload compare off: filter takes extended frames only; base and extension must match.
// - Mask type-match set, payload compare off: frame identifier type must equal the filter's type bit.
// - Each filter names a destination FIFO and selects one of the masks.
// - Zero mask bits drop identifier bits from comparison; 0x7FC ignores two low bits.
// - Five-bit payload match count in control register; zero turns payload compare off.
// - Count n compares first n payload bits from byte 0 bit 7 with extension bits from 17.
// - Payload mode accepts when base identifier and selected payload bits both match.
// - Payload mode needs a standard frame; extended frames are never accepted there.
// - Count three compares byte 0 bits 7..5 with extension bits 17..15.
// - Payload compare stops at 18 bits, byte 2 bit 6.
// - Count above 16 with length 2 stops after byte 1 bit 0.
// - Count above 8 with length 1 stops after byte 0 bit 0.
// - Nonzero count with length 0 accepts on base identifier match alone.
// - Filters hold an 18-bit extension field beside the 11-bit base field.
// - Payload matching compares up to 18 data bits against the extension field.
// - Mask bits set to one force comparison of that filter bit.
// - Mask type-match clear, payload compare off: frame type is ignored, identifier bits decide.
// - Lowest-numbered matching filter whose FIFO has room decides the destination.
package can_filter_pkg;

  localparam int ADDR_W   = 12;
  localparam int FIFO_W   = 5;
  localparam int MASK_W   = 2;
  localparam int DATA_MATCH_BIT_COUNT_W  = 5;
  localparam int PAY_W    = 18;

  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] MASK_BASE  = 12'h010;
  localparam logic [11:0] FVAL_BASE  = 12'h100;
  localparam logic [11:0] FCTL_BASE  = 12'h200;

  localparam logic [4:0] DATA_MATCH_BIT_COUNT_RST = 5'h00;
  localparam logic [4:0] DN_MAX    = 5'h12;
  localparam logic [4:0] DN_DLC2   = 5'h10;
  localparam logic [4:0] DN_DLC1   = 5'h08;
  localparam logic [3:0] DLC_0     = 4'h0;
  localparam logic [3:0] DLC_1     = 4'h1;
  localparam logic [3:0] DLC_2     = 4'h2;

  // Filter value: sid 31:21, type 19, extension 17:0
  typedef struct packed {
    logic [10:0] sid;
    logic        rsv_a;
    logic        filter_extended_type_select;
    logic        rsv_b;
    logic [17:0] eid;
  } acc_filter_type;

  // Mask: same layout, type-match enable at 19
  typedef struct packed {
    logic [10:0] sid;
    logic        rsv_a;
    logic        mask_type_match_enable;
    logic        rsv_b;
    logic [17:0] eid;
  } acc_mask_type;

  typedef struct packed {
    logic [23:0] rsv;
    logic        en;
    logic [1:0]  msel;
    logic [4:0]  fifo;
  } filter_ctl_type;

  typedef struct packed {
    logic        valid;
    logic        ide;
    logic [10:0] sid;
    logic [17:0] eid;
    logic [3:0]  dlc;
    logic [7:0]  data0;
    logic [7:0]  data1;
    logic [7:0]  data2;
  } rx_frame_type;

  typedef struct packed {
    logic       done;
    logic       accept;
    logic [4:0] hit;
    logic [4:0] dest;
  } match_result_type;

endpackage

// file: src/can_acceptance_filter.sv
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_filter #(
  parameter int NUM_FILTERS = 32,
  parameter int NUM_MASKS   = 4,
  parameter int NUM_FIFOS   = 32
) (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst,
  // Register port
  input  wire logic [can_filter_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                      wdata,
  input  wire logic                             wr,
  input  wire logic                             rd,
  output logic      [31:0]                      rdata,
  // Assembled frame and FIFO space
  input  wire can_filter_pkg::rx_frame_type     frame,
  input  wire logic [NUM_FIFOS-1:0]             fifo_room,
  // Filtering outcome
  output can_filter_pkg::match_result_type      result
);

  typedef struct packed {
    logic [4:0]                                      data_match_bit_count;
    can_filter_pkg::acc_mask_type [NUM_MASKS-1:0]    masks;
    can_filter_pkg::acc_filter_type [NUM_FILTERS-1:0] fval;
    can_filter_pkg::filter_ctl_type [NUM_FILTERS-1:0] fctl;
    logic [31:0]                                     rdata;
    can_filter_pkg::match_result_type                res;
    can_filter_pkg::match_result_type                last;
  } state_type;

  state_type                    st_ff;
  state_type                    nxt_st;
  logic [NUM_FILTERS-1:0]       hit_vec;
  logic [NUM_MASKS-1:0]         mask_busy;
  logic [4:0]                   eff_n;
  logic [17:0]                  payload;
  logic [17:0]                  dsel;
  logic                         any_win;
  logic [4:0]                   win_idx;
  logic [4:0]                   widx;

  assign rdata   = st_ff.rdata;
  assign result  = st_ff.res;
  assign widx    = addr[6:2];
  assign payload = {frame.data0, frame.data1, frame.data2[7:6]};

  // Payload bit budget, clipped by length code
  always_comb begin
    eff_n = (st_ff.data_match_bit_count > can_filter_pkg::DN_MAX) ? can_filter_pkg::DN_MAX : st_ff.data_match_bit_count;
    if (frame.dlc == can_filter_pkg::DLC_0) begin
      eff_n = 5'h00;
    end else if (frame.dlc == can_filter_pkg::DLC_1 && eff_n > can_filter_pkg::DN_DLC1) begin
      eff_n = can_filter_pkg::DN_DLC1;
    end else if (frame.dlc == can_filter_pkg::DLC_2 && eff_n > can_filter_pkg::DN_DLC2) begin
      eff_n = can_filter_pkg::DN_DLC2;
    end
    for (int i = 0; i < can_filter_pkg::PAY_W; i++) begin
      dsel[i] = (5'(17 - i) < eff_n);
    end
  end

  // Per-filter comparison and priority pick
  always_comb begin
    can_filter_pkg::acc_mask_type   m;
    can_filter_pkg::acc_filter_type fv;
    logic                           sid_ok;
    logic                           eid_ok;
    logic                           dat_ok;
    logic                           ok;
    m         = '0;
    fv        = '0;
    sid_ok    = 1'b0;
    eid_ok    = 1'b0;
    dat_ok    = 1'b0;
    ok        = 1'b0;
    hit_vec   = '0;
    mask_busy = '0;
    any_win   = 1'b0;
    win_idx   = 5'h00;
    for (int f = 0; f < NUM_FILTERS; f++) begin
      m      = st_ff.masks[st_ff.fctl[f].msel];
      fv     = st_ff.fval[f];
      sid_ok = ((frame.sid ^ fv.sid) & m.sid) == 11'h000;
      eid_ok = ((frame.eid ^ fv.eid) & m.eid) == 18'h00000;
      dat_ok = ((payload ^ fv.eid) & m.eid & dsel) == 18'h00000;
      if (st_ff.data_match_bit_count != can_filter_pkg::DATA_MATCH_BIT_COUNT_RST) begin
        ok = !frame.ide && sid_ok && dat_ok;
      end else if (m.mask_type_match_enable) begin
        ok = (frame.ide == fv.filter_extended_type_select) && sid_ok && (!frame.ide || eid_ok);
      end else begin
        ok = sid_ok && (!frame.ide || eid_ok);
      end
      hit_vec[f] = frame.valid && st_ff.fctl[f].en && ok;
      if (st_ff.fctl[f].en) begin
        mask_busy[st_ff.fctl[f].msel] = 1'b1;
      end
    end
    // Downward scan leaves the lowest usable filter
    for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
      if (hit_vec[f] && fifo_room[st_ff.fctl[f].fifo]) begin
        any_win = 1'b1;
        win_idx = 5'(f);
      end
    end
  end

  always_comb begin
    can_filter_pkg::acc_filter_type wf;
    can_filter_pkg::acc_mask_type   wm;
    can_filter_pkg::filter_ctl_type wc;
    wf = wdata;
    wm = wdata;
    wc = wdata;
    wf.rsv_a = 1'b0;
    wf.rsv_b = 1'b0;
    wm.rsv_a = 1'b0;
    wm.rsv_b = 1'b0;
    wc.rsv   = '0;
    nxt_st = st_ff;
    nxt_st.rdata = 32'h00000000;
    nxt_st.res = '0;
    nxt_st.res.done = frame.valid;
    nxt_st.res.accept = frame.valid && any_win;
    if (frame.valid && any_win) begin
      nxt_st.res.hit  = win_idx;
      nxt_st.res.dest = st_ff.fctl[win_idx].fifo;
    end
    if (frame.valid) begin
      nxt_st.last = nxt_st.res;
    end
    // Writes; values of enabled filters and their masks stay frozen
    if (wr && addr[1:0] == 2'b00) begin
      if (addr == can_filter_pkg::CTRL_OFS) begin
        nxt_st.data_match_bit_count = wdata[4:0];
      end else if (addr[11:4] == can_filter_pkg::MASK_BASE[11:4] && int'(addr[3:2]) < NUM_MASKS) begin
        if (!mask_busy[addr[3:2]]) begin
          nxt_st.masks[addr[3:2]] = wm;
        end
      end else if (addr[11:7] == can_filter_pkg::FVAL_BASE[11:7] && int'(widx) < NUM_FILTERS) begin
        if (!st_ff.fctl[widx].en) begin
          nxt_st.fval[widx] = wf;
        end
      end else if (addr[11:7] == can_filter_pkg::FCTL_BASE[11:7] && int'(widx) < NUM_FILTERS) begin
        nxt_st.fctl[widx] = wc;
      end
    end
    // Reads answer in the following cycle; unmapped reads give zero
    if (rd && addr[1:0] == 2'b00) begin
      if (addr == can_filter_pkg::CTRL_OFS) begin
        nxt_st.rdata = {27'h0000000, st_ff.data_match_bit_count};
      end else if (addr == can_filter_pkg::STATUS_OFS) begin
        nxt_st.rdata = {20'h00000, st_ff.last};
      end else if (addr[11:4] == can_filter_pkg::MASK_BASE[11:4] && int'(addr[3:2]) < NUM_MASKS) begin
        nxt_st.rdata = st_ff.masks[addr[3:2]];
      end else if (addr[11:7] == can_filter_pkg::FVAL_BASE[11:7] && int'(widx) < NUM_FILTERS) begin
        nxt_st.rdata = st_ff.fval[widx];
      end else if (addr[11:7] == can_filter_pkg::FCTL_BASE[11:7] && int'(widx) < NUM_FILTERS) begin
        nxt_st.rdata = st_ff.fctl[widx];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_std_only;
    frame.valid && st_ff.data_match_bit_count == 5'h00 && st_ff.masks[st_ff.fctl[0].msel].mask_type_match_enable && !st_ff.fval[0].filter_extended_type_select
      && frame.ide |-> !hit_vec[0];
  endproperty
  a_std_only: assert property (p_std_only) else $error("standard filter hit an extended frame");

  property p_ext_only;
    frame.valid && st_ff.data_match_bit_count == 5'h00 && st_ff.masks[st_ff.fctl[0].msel].mask_type_match_enable && st_ff.fval[0].filter_extended_type_select
      && !frame.ide |-> !hit_vec[0];
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("extended filter hit a standard frame");

  property p_mask_ignore;
    frame.valid && st_ff.data_match_bit_count == 5'h00 && !frame.ide && st_ff.fctl[0].en
      && !st_ff.masks[st_ff.fctl[0].msel].mask_type_match_enable
      && ((frame.sid ^ st_ff.fval[0].sid) & st_ff.masks[st_ff.fctl[0].msel].sid) == 11'h000 |-> hit_vec[0];
  endproperty
  a_mask_ignore: assert property (p_mask_ignore) else $error("masked standard match missed");

  property p_data_no_ext;
    frame.valid && st_ff.data_match_bit_count != 5'h00 && frame.ide |-> hit_vec == '0;
  endproperty
  a_data_no_ext: assert property (p_data_no_ext) else $error("payload mode took an extended frame");

  property p_dlc0;
    frame.valid && st_ff.data_match_bit_count != 5'h00 && frame.dlc == 4'h0 && !frame.ide && st_ff.fctl[0].en
      && ((frame.sid ^ st_ff.fval[0].sid) & st_ff.masks[st_ff.fctl[0].msel].sid) == 11'h000 |-> hit_vec[0];
  endproperty
  a_dlc0: assert property (p_dlc0) else $error("empty payload did not accept on identifier");

  property p_limit18;
    frame.valid |-> eff_n <= 5'h12 && (st_ff.data_match_bit_count < 5'h13 || frame.dlc < 4'h3 || eff_n == 5'h12);
  endproperty
  a_limit18: assert property (p_limit18) else $error("payload count beyond 18 bits");

  property p_dlc2;
    frame.valid && frame.dlc == 4'h2 && st_ff.data_match_bit_count > 5'h10 |-> eff_n == 5'h10;
  endproperty
  a_dlc2: assert property (p_dlc2) else $error("two-byte payload limit wrong");

  property p_dlc1;
    frame.valid && frame.dlc == 4'h1 && st_ff.data_match_bit_count > 5'h08 |-> eff_n == 5'h08;
  endproperty
  a_dlc1: assert property (p_dlc1) else $error("one-byte payload limit wrong");

  property p_prio0;
    frame.valid && hit_vec[0] && fifo_room[st_ff.fctl[0].fifo]
      |=> result.accept && result.hit == 5'h00 && result.dest == $past(st_ff.fctl[0].fifo);
  endproperty
  a_prio0: assert property (p_prio0) else $error("filter 0 did not win");

  property p_no_room;
    frame.valid && !any_win |=> result.done && !result.accept;
  endproperty
  a_no_room: assert property (p_no_room) else $error("accept without a usable filter");

endmodule
`default_nettype wire

// file: dv/rx_frame_source.sv
`timescale 1ns/1ps
`default_nettype none
module rx_frame_source (
  // Clock
  input  wire logic                        clk,
  // Assembled frame toward the filter
  output var can_filter_pkg::rx_frame_type frame
);
  initial frame = '0;

  // Payload runs data0[7] first down to data2[6]
  task automatic send(input logic ide, input logic [10:0] sid, input logic [17:0] eid,
                      input logic [3:0] dlc, input logic [17:0] pay);
    @(posedge clk);
    frame <= {1'b1, ide, sid, eid, dlc, pay, 6'h00};
    @(posedge clk);
    // Stale fields must not look like the last frame
    frame <= {1'b0, ~frame[$bits(frame)-2:0]};
  endtask
endmodule
`default_nettype wire

// file: dv/can_acceptance_filter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_filter_tb;
  localparam logic [11:0] MK = can_filter_pkg::MASK_BASE;
  localparam logic [11:0] FV = can_filter_pkg::FVAL_BASE;
  localparam logic [11:0] FC = can_filter_pkg::FCTL_BASE;
  localparam logic [17:0] PAY = 18'h1c498;
  logic                              clk = 1'b0;
  logic                              rst = 1'b1;
  logic [can_filter_pkg::ADDR_W-1:0] addr = '0;
  logic [31:0]                       wdata = '0;
  logic                              wr = 1'b0;
  logic                              rd = 1'b0;
  logic [31:0]                       rdata;
  logic [31:0]                       fifo_room = '1;
  can_filter_pkg::rx_frame_type      frame;
  can_filter_pkg::match_result_type  result;
  int                                error_cnt = 0;
  int                                n_tests = 0;

  always #12.5 clk = ~clk;

  can_acceptance_filter DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                             .rdata(rdata), .frame(frame), .fifo_room(fifo_room), .result(result));
  rx_frame_source src (.clk(clk), .frame(frame));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask

  // One frame, result judged in the cycle after valid
  task automatic fchk(input logic ide, input logic [10:0] sid, input logic [17:0] eid, input logic [3:0] dlc,
                      input logic [17:0] pay, input logic acc, input logic [4:0] hit, input logic [4:0] dest);
    src.send(ide, sid, eid, dlc, pay);
    #1 chk("result", {20'h0, result}, {20'h0, 1'b1, acc, acc ? hit : 5'h00, acc ? dest : 5'h00});
  endtask

  task automatic t_reset();
    rchk(can_filter_pkg::CTRL_OFS, 32'h0);
    rchk(can_filter_pkg::STATUS_OFS, 32'h0);
    rchk(FC, 32'h0);
    rchk(12'h800, 32'h0);
    $display("test reset done");
  endtask

  // Enable goes in last, after every other field
  task automatic t_std();
    wreg(FV, 32'h20000000);
    wreg(MK, 32'hff880000);
    wreg(FC, 32'h00000085);
    rchk(FC, 32'h00000085);
    fchk(1'b0, 11'h103, 18'h0, 4'h8, 18'h0, 1'b1, 5'h00, 5'h05);
    fchk(1'b0, 11'h104, 18'h0, 4'h8, 18'h0, 1'b0, 5'h00, 5'h00);
    fchk(1'b1, 11'h103, 18'h0, 4'h8, 18'h0, 1'b0, 5'h00, 5'h00);
    wreg(FV, 32'h0);
    rchk(FV, 32'h20000000);
    $display("test standard done");
  endtask

  task automatic t_ext();
    wreg(FV + 12'h004, 32'h0a69c498);
    wreg(MK + 12'h004, 32'hffebffff);
    wreg(FC + 12'h004, 32'h000000a7);
    fchk(1'b1, 11'h053, PAY, 4'h8, 18'h0, 1'b1, 5'h01, 5'h07);
    rchk(can_filter_pkg::STATUS_OFS, 32'h00000c27);
    fchk(1'b1, 11'h053, PAY ^ 18'h1, 4'h8, 18'h0, 1'b0, 5'h00, 5'h00);
    fchk(1'b0, 11'h053, 18'h0, 4'h8, 18'h0, 1'b0, 5'h00, 5'h00);
    $display("test extended done");
  endtask

  task automatic t_type_prio();
    wreg(FV + 12'h008, 32'h05400000);
    wreg(FV + 12'h00c, 32'h05400000);
    wreg(MK + 12'h008, 32'hffe3ffff);
    wreg(FC + 12'h008, 32'h000000c3);
    wreg(FC + 12'h00c, 32'h000000c4);
    fchk(1'b0, 11'h02a, 18'h0, 4'h8, 18'h0, 1'b1, 5'h02, 5'h03);
    fchk(1'b1, 11'h02a, 18'h0, 4'h8, 18'h0, 1'b1, 5'h02, 5'h03);
    fchk(1'b1, 11'h02a, 18'h4, 4'h8, 18'h0, 1'b0, 5'h00, 5'h00);
    @(posedge clk);
    fifo_room[3] <= 1'b0;
    fchk(1'b0, 11'h02a, 18'h0, 4'h8, 18'h0, 1'b1, 5'h03, 5'h04);
    @(posedge clk);
    fifo_room[4] <= 1'b0;
    fchk(1'b0, 11'h02a, 18'h0, 4'h8, 18'h0, 1'b0, 5'h00, 5'h00);
    @(posedge clk);
    fifo_room <= '1;
    $display("test type and priority done");
  endtask

  // Flip index 18 leaves the payload intact
  task automatic t_data_match();
    int   n[12]  = '{1, 1, 3, 3, 18, 31, 31, 20, 20, 12, 12, 5};
    int   dl[12] = '{8, 8, 8, 8, 8, 8, 8, 2, 2, 1, 1, 0};
    int   k[12]  = '{1, 0, 3, 2, 17, 17, 18, 16, 15, 8, 7, 0};
    logic ok[12] = '{1, 0, 1, 0, 0, 0, 1, 1, 0, 1, 0, 1};
    fchk(1'b0, 11'h053, 18'h0, 4'h8, PAY, 1'b0, 5'h00, 5'h00);
    for (int i = 0; i < 12; i++) begin
      wreg(can_filter_pkg::CTRL_OFS, n[i]);
      fchk(1'b0, 11'h053, 18'h0, dl[i][3:0], PAY ^ (18'h20000 >> k[i]), ok[i], 5'h01, 5'h07);
    end
    rchk(can_filter_pkg::CTRL_OFS, 32'h5);
    fchk(1'b0, 11'h052, 18'h0, 4'h0, PAY, 1'b0, 5'h00, 5'h00);
    fchk(1'b1, 11'h053, PAY, 4'h8, PAY, 1'b0, 5'h00, 5'h00);
    $display("test data match done");
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_std();
    t_ext();
    t_type_prio();
    t_data_match();
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("Watchdog expired");
    end_of_test();
  end
endmodule
`default_nettype wire
